//--- hw/cmp_pkg.sv
package cmp_pkg;
    // target addresses selected by the address select pin
    localparam logic [6:0] CMP_ADDR_LO = 7'h0C;
    localparam logic [6:0] CMP_ADDR_HI = 7'h0D;
    // master code prefix for high-speed entry, upper five bits
    localparam logic [4:0] CMP_HS_CODE = 5'h01;
    // register address groups and wrap points
    localparam logic [7:0] CMP_G0_FIRST = 8'h00;
    localparam logic [7:0] CMP_G0_GAP = 8'h03;
    localparam logic [7:0] CMP_G0_JUMP = 8'h10;
    localparam logic [7:0] CMP_G0_LAST = 8'h18;
    localparam logic [7:0] CMP_G1_FIRST = 8'h30;
    localparam logic [7:0] CMP_G1_LAST = 8'h32;
    localparam logic [7:0] CMP_G2_FIRST = 8'h60;
    localparam logic [7:0] CMP_G2_LAST = 8'h62;
    // bus rates, kHz, and the system clock in kHz
    localparam int CMP_MCLK_KHZ = 250000;
    localparam int CMP_STD_KHZ = 100;
    localparam int CMP_FAST_KHZ = 400;
    localparam int CMP_HS_KHZ = 2500;
    // controller tick: four ticks make one bus clock period, rounded so the rate stays
    // at or just below fast mode
    localparam int CMP_HALF_CYC_I = CMP_MCLK_KHZ / (4 * CMP_FAST_KHZ);
    localparam logic [9:0] CMP_HALF_CYC = CMP_HALF_CYC_I[9:0];
    // glitch filter length in samples
    localparam logic [1:0] CMP_FILT_LEN = 2'h3;
    localparam logic [3:0] CMP_BIT_LAST = 4'h7;
    localparam logic [3:0] CMP_BIT_ACK = 4'h8;
    localparam logic [3:0] CMP_BIT_ZERO = 4'h0;
endpackage

//--- hw/cmp_bus_if.sv
`timescale 1ns/1ps
// two-wire bus: open-drain, wire is low if any party enables its driver
interface cmp_bus_if;
    logic scl_oe;
    logic sda_oe_ctl;
    logic sda_oe_tgt;
    logic scl;
    logic sda;
    assign scl = ~scl_oe;
    assign sda = ~(sda_oe_ctl | sda_oe_tgt);
    modport target (input scl, input sda, output sda_oe_tgt);
    modport controller (input scl, input sda, output scl_oe, output sda_oe_ctl);
endinterface

//--- hw/cmp_target.sv
`timescale 1ns/1ps
// Contract
// RULE1: sda falls while scl high is start
// RULE2: sda rises while scl high is stop
// RULE3: change sda only while scl low
// RULE4: address 0CH if select low, 0DH high
// RULE5: last bit of first byte is direction
// RULE6: acknowledge only own address, else passive
// RULE7: receiver pulls sda low on ack
// RULE8: second write byte is register address
// RULE9: data bytes msb first, each acknowledged
// RULE10: further write bytes go to next address
// RULE11: low group 00-03,10-18, wraps to 00
// RULE12: wrap 32 to 30, 62 to 60
// RULE13: writes to read-only locations are dropped
// RULE14: controller ack continues read, nack ends
// RULE15: counter holds next address after access
// RULE16: random read via write address, restart
// RULE17: master code gets nack, then high speed
// RULE18: stop returns to fast mode
// RULE19: bus rates up to 2.5 MHz
// RULE20: lines synchronised and glitch filtered
module cmp_target
    import cmp_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    cmp_bus_if.target bus,
    input wire logic address_select_pin,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    output logic hs_mode
);
    typedef enum logic [2:0] {
        CMP_IDLE = 3'b000,
        CMP_ADDR = 3'b001,
        CMP_AACK = 3'b011,
        CMP_RXB = 3'b010,
        CMP_RACK = 3'b110,
        CMP_TXB = 3'b111,
        CMP_TACK = 3'b101
    } cmp_state_t;

    typedef struct packed {
        logic [1:0] scl_sy;
        logic [1:0] sda_sy;
        logic [1:0] scl_cnt;
        logic [1:0] sda_cnt;
        logic scl_f;
        logic sda_f;
        logic [1:0] sel;
        cmp_state_t st;
        logic [3:0] bitn;
        logic [7:0] sh;
        logic rd;
        logic hs_arm;
        logic hs;
        logic have_ptr;
        logic [7:0] ptr;
        logic oe;
        logic wr;
        logic [7:0] wdata;
        logic [7:0] waddr;
        logic mack;
        logic [7:0] raddr;
    } cmp_tgt_t;

    cmp_tgt_t q_r, q_nxt;
    logic scl_rise, scl_fall, start_c, stop_c, scl_i, sda_i;

    // address step with group wrap; addresses outside the groups just count up
    function automatic logic [7:0] cmp_step(input logic [7:0] a);
        logic [7:0] n;
        n = a + 8'h01;
        if (a == CMP_G0_GAP) n = CMP_G0_JUMP; // see RULE11
        else if (a == CMP_G0_LAST) n = CMP_G0_FIRST; // see RULE11
        else if (a == CMP_G1_LAST) n = CMP_G1_FIRST; // see RULE12
        else if (a == CMP_G2_LAST) n = CMP_G2_FIRST; // see RULE12
        return n;
    endfunction

    // only the control group is writable
    function automatic logic cmp_writable(input logic [7:0] a);
        return (a >= CMP_G1_FIRST) && (a <= CMP_G1_LAST); // see RULE13
    endfunction

    always_comb begin
        // filtered line values and edges come from registered state only
        scl_i = q_r.scl_sy[1];
        sda_i = q_r.sda_sy[1];
        q_nxt = q_r;
        q_nxt.wr = 1'b0;
        // two-stage synchroniser, first stage read only by second
        q_nxt.scl_sy = {q_r.scl_sy[0], bus.scl}; // see RULE20
        q_nxt.sda_sy = {q_r.sda_sy[0], bus.sda}; // see RULE20
        // a level must persist for one sample more than the filter length before it is taken
        if (scl_i == q_r.scl_f) q_nxt.scl_cnt = 2'h0;
        else if (q_r.scl_cnt == CMP_FILT_LEN) q_nxt.scl_f = scl_i; // see RULE20
        else q_nxt.scl_cnt = q_r.scl_cnt + 2'h1;
        if (sda_i == q_r.sda_f) q_nxt.sda_cnt = 2'h0;
        else if (q_r.sda_cnt == CMP_FILT_LEN) q_nxt.sda_f = sda_i; // see RULE20
        else q_nxt.sda_cnt = q_r.sda_cnt + 2'h1;
        scl_rise = q_nxt.scl_f & ~q_r.scl_f;
        scl_fall = ~q_nxt.scl_f & q_r.scl_f;
        start_c = q_r.scl_f & q_nxt.scl_f & q_r.sda_f & ~q_nxt.sda_f; // see RULE1
        stop_c = q_r.scl_f & q_nxt.scl_f & ~q_r.sda_f & q_nxt.sda_f; // see RULE2
        // the strap passes two flops like any pin; reset clears both
        q_nxt.sel = {q_r.sel[0], address_select_pin};
        if (stop_c) begin
            q_nxt.st = CMP_IDLE;
            q_nxt.oe = 1'b0;
            q_nxt.hs = 1'b0; // see RULE18
            q_nxt.hs_arm = 1'b0;
        end else if (start_c) begin
            q_nxt.st = CMP_ADDR;
            q_nxt.bitn = CMP_BIT_ZERO;
            q_nxt.oe = 1'b0;
            if (q_r.hs_arm) q_nxt.hs = 1'b1; // see RULE17
            q_nxt.hs_arm = 1'b0;
        end else begin
            unique case (q_r.st)
                CMP_IDLE: begin
                    q_nxt.oe = 1'b0;
                end
                CMP_ADDR, CMP_RXB: begin
                    // sample on rising scl, msb first
                    if (scl_rise) begin
                        q_nxt.sh = {q_r.sh[6:0], q_r.sda_f}; // see RULE9
                        q_nxt.bitn = q_r.bitn + 4'h1;
                    end
                    // drive ack only after the falling edge ending bit 8
                    if (scl_fall && q_r.bitn == CMP_BIT_ACK) begin
                        q_nxt.bitn = CMP_BIT_ZERO;
                        if (q_r.st == CMP_ADDR) begin
                            if (q_r.sh[7:1] == (q_r.sel[1] ? CMP_ADDR_HI : CMP_ADDR_LO)) begin
                                q_nxt.oe = 1'b1; // see RULE4
                                q_nxt.rd = q_r.sh[0]; // see RULE5
                                q_nxt.have_ptr = 1'b0;
                                q_nxt.st = CMP_AACK; // see RULE6
                            end else begin
                                // master code: nack by staying released
                                if (!q_r.hs && q_r.sh[7:3] == CMP_HS_CODE) begin
                                    q_nxt.hs_arm = 1'b1; // see RULE17
                                end
                                q_nxt.st = CMP_IDLE; // see RULE6
                            end
                        end else begin
                            q_nxt.oe = 1'b1; // see RULE7
                            q_nxt.st = CMP_RACK;
                            if (!q_r.have_ptr) begin
                                q_nxt.ptr = q_r.sh; // see RULE8
                                q_nxt.have_ptr = 1'b1;
                            end else begin
                                q_nxt.waddr = q_r.ptr;
                                q_nxt.wdata = q_r.sh;
                                q_nxt.wr = cmp_writable(q_r.ptr); // see RULE13
                                q_nxt.ptr = cmp_step(q_r.ptr); // see RULE10
                            end
                        end
                    end
                end
                CMP_AACK, CMP_RACK: begin
                    // release the ack after its clock pulse, on scl low
                    if (scl_fall) begin
                        q_nxt.oe = 1'b0; // see RULE3
                        if (q_r.st == CMP_AACK && q_r.rd) begin
                            // current or random read from the counter
                            q_nxt.sh = reg_rdata; // see RULE15
                            q_nxt.oe = ~reg_rdata[7]; // see RULE16
                            q_nxt.ptr = cmp_step(q_r.ptr); // see RULE15
                            q_nxt.bitn = CMP_BIT_ZERO;
                            q_nxt.st = CMP_TXB;
                        end else begin
                            q_nxt.st = CMP_RXB;
                        end
                    end
                end
                CMP_TXB: begin
                    // shift on falling scl, so sda moves only while low
                    if (scl_fall) begin
                        q_nxt.bitn = q_r.bitn + 4'h1;
                        if (q_r.bitn == CMP_BIT_LAST) begin
                            q_nxt.oe = 1'b0; // see RULE14
                            q_nxt.st = CMP_TACK;
                        end else begin
                            q_nxt.sh = {q_r.sh[6:0], 1'b0};
                            q_nxt.oe = ~q_r.sh[6]; // see RULE3
                        end
                    end
                end
                CMP_TACK: begin
                    // answer taken while scl high, acted on once scl is low again
                    if (scl_rise) q_nxt.mack = ~q_r.sda_f; // see RULE14
                    if (scl_fall) begin
                        if (q_r.mack) begin
                            // msb must go out now, before the first data pulse
                            q_nxt.sh = reg_rdata; // see RULE14
                            q_nxt.oe = ~reg_rdata[7]; // see RULE3
                            q_nxt.ptr = cmp_step(q_r.ptr); // see RULE15
                            q_nxt.bitn = CMP_BIT_ZERO;
                            q_nxt.st = CMP_TXB;
                        end else begin
                            q_nxt.st = CMP_IDLE; // see RULE14
                        end
                    end
                end
                default: q_nxt.st = CMP_IDLE;
            endcase
        end
        // register file address from a flop; write address only in the strobe cycle
        q_nxt.raddr = q_nxt.wr ? q_nxt.waddr : q_nxt.ptr;
    end

    // one register for all state; lines start released and idle high
    always_ff @(posedge mclk) begin
        if (reset) begin
            q_r <= '0;
            q_r.scl_sy <= 2'h3;
            q_r.sda_sy <= 2'h3;
            q_r.scl_f <= 1'b1;
            q_r.sda_f <= 1'b1;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign bus.sda_oe_tgt = q_r.oe;
    assign reg_addr = q_r.raddr;
    assign reg_wr = q_r.wr;
    assign reg_wdata = q_r.wdata;
    assign hs_mode = q_r.hs; // see RULE19
endmodule // cmp_target

//--- hw/cmp_controller.sv
`timescale 1ns/1ps
module cmp_controller
    import cmp_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    cmp_bus_if.controller bus,
    input wire logic cmd_valid,
    input wire logic cmd_start,
    input wire logic cmd_stop,
    input wire logic cmd_read,
    input wire logic cmd_nack,
    input wire logic [7:0] cmd_data,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic rsp_ack
);
    typedef enum logic [2:0] {
        CMC_IDLE = 3'b000,
        CMC_START = 3'b001,
        CMC_BIT = 3'b011,
        CMC_STOP = 3'b010,
        CMC_HOLD = 3'b110
    } cmc_state_t;

    typedef struct packed {
        logic [1:0] sda_sy;
        cmc_state_t st;
        logic [9:0] cnt;
        logic [1:0] ph;
        logic [3:0] bitn;
        logic [7:0] sh;
        logic rd;
        logic nack;
        logic stop;
        logic scl_oe;
        logic sda_oe;
        logic busy;
        logic rv;
        logic [7:0] rdat;
        logic rack;
        logic rdy;
    } cmc_t;

    cmc_t q_r, q_nxt;
    logic tick;

    // start/stop only with scl high; data changes only in low phase
    always_comb begin
        q_nxt = q_r;
        q_nxt.rv = 1'b0;
        q_nxt.sda_sy = {q_r.sda_sy[0], bus.sda}; // see RULE20
        tick = (q_r.cnt == CMP_HALF_CYC); // see RULE19
        q_nxt.cnt = tick ? 10'h000 : q_r.cnt + 10'h001;
        unique case (q_r.st)
            CMC_IDLE: begin
                q_nxt.cnt = 10'h000;
                if (cmd_valid) begin
                    q_nxt.busy = 1'b1;
                    q_nxt.rd = cmd_read;
                    q_nxt.nack = cmd_nack;
                    q_nxt.stop = cmd_stop;
                    q_nxt.sh = cmd_read ? 8'hFF : cmd_data;
                    q_nxt.bitn = CMP_BIT_ZERO;
                    q_nxt.ph = 2'h0;
                    q_nxt.st = cmd_start ? CMC_START : CMC_BIT;
                end
            end
            CMC_START: if (tick) begin
                // release sda, raise scl, then pull sda low
                q_nxt.ph = q_r.ph + 2'h1;
                unique case (q_r.ph)
                    2'h0: q_nxt.sda_oe = 1'b0;
                    2'h1: q_nxt.scl_oe = 1'b0;
                    2'h2: q_nxt.sda_oe = 1'b1; // see RULE1
                    2'h3: begin
                        q_nxt.scl_oe = 1'b1;
                        q_nxt.st = CMC_BIT;
                    end
                endcase
            end
            CMC_BIT: if (tick) begin
                q_nxt.ph = q_r.ph + 2'h1;
                unique case (q_r.ph)
                    2'h0: begin
                        // set sda in low phase; ack slot for reads is ours
                        if (q_r.bitn == CMP_BIT_ACK) q_nxt.sda_oe = q_r.rd & ~q_r.nack; // see RULE7
                        else q_nxt.sda_oe = ~q_r.sh[7]; // see RULE3
                    end
                    2'h1: q_nxt.scl_oe = 1'b0;
                    2'h2: begin
                        if (q_r.bitn == CMP_BIT_ACK) q_nxt.rack = ~q_r.sda_sy[1];
                        else q_nxt.sh = {q_r.sh[6:0], q_r.sda_sy[1]}; // see RULE9
                    end
                    2'h3: begin
                        q_nxt.scl_oe = 1'b1;
                        q_nxt.ph = 2'h0;
                        q_nxt.bitn = q_r.bitn + 4'h1;
                        if (q_r.bitn == CMP_BIT_ACK) begin
                            q_nxt.rv = 1'b1;
                            q_nxt.rdat = q_r.sh;
                            q_nxt.st = q_r.stop ? CMC_STOP : CMC_HOLD; // see RULE14
                        end
                    end
                endcase
            end
            CMC_STOP: if (tick) begin
                q_nxt.ph = q_r.ph + 2'h1;
                unique case (q_r.ph)
                    2'h0: q_nxt.sda_oe = 1'b1;
                    2'h1: q_nxt.scl_oe = 1'b0;
                    2'h2: q_nxt.sda_oe = 1'b0; // see RULE2
                    2'h3: q_nxt.st = CMC_IDLE;
                endcase
            end
            CMC_HOLD: begin
                // scl held low between bytes of one transaction
                q_nxt.cnt = 10'h000;
                q_nxt.st = CMC_IDLE;
            end
            default: q_nxt.st = CMC_IDLE;
        endcase
        if (q_nxt.st == CMC_IDLE && q_r.st != CMC_IDLE) q_nxt.busy = 1'b0;
        // ready from a flop, so the command side never sees a glitch
        q_nxt.rdy = (q_nxt.st == CMC_IDLE) & ~q_nxt.busy;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            q_r <= '0;
            q_r.sda_sy <= 2'h3;
            q_r.rdy <= 1'b1;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign bus.scl_oe = q_r.scl_oe;
    assign bus.sda_oe_ctl = q_r.sda_oe;
    assign cmd_ready = q_r.rdy;
    assign rsp_valid = q_r.rv;
    assign rsp_data = q_r.rdat;
    assign rsp_ack = q_r.rack;
endmodule // cmp_controller

//--- test/cmp_bus_monitor.sv
`timescale 1ns/1ps
// wire-level checks on the shared two-wire bus, both ends being design code
module cmp_bus_monitor (
    input wire logic mclk,
    input wire logic reset,
    input wire logic scl_oe,
    input wire logic sda_oe_ctl,
    input wire logic sda_oe_tgt,
    input wire logic scl,
    input wire logic sda
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    logic scl_d_r;
    logic [7:0] since_rise_r;
    logic [7:0] since_rise_nxt;
    logic [10:0] drive_wait_r;
    logic [10:0] drive_wait_nxt;
    // cycles since the last clock rise, saturating so a long idle never looks fast
    always_comb begin
        since_rise_nxt = (since_rise_r == 8'hFF) ? 8'hFF : since_rise_r + 8'h01;
        if (scl && !scl_d_r) since_rise_nxt = 8'h00;
    end
    // cycles the target has held data low with no clock rise since; saturates
    always_comb begin
        drive_wait_nxt = (drive_wait_r == 11'h7FF) ? 11'h7FF : drive_wait_r + 11'h001;
        if (!sda_oe_tgt || (scl && !scl_d_r)) drive_wait_nxt = 11'h000;
    end
    always_ff @(posedge mclk) begin
        scl_d_r <= reset ? 1'b1 : scl;
        since_rise_r <= reset ? 8'hFF : since_rise_nxt;
        drive_wait_r <= reset ? 11'h000 : drive_wait_nxt;
    end
    sequence start_ev;
        scl && $past(scl) && $fell(sda);
    endsequence
    sequence stop_ev;
        scl && $past(scl) && $rose(sda);
    endsequence
    a_reset_lines_free: assert property ($fell(reset) |-> !sda_oe_tgt && !sda_oe_ctl && !scl_oe)
        else $error("bus line driven right after reset");
    a_tgt_sda_steady: assert property (scl && $past(scl) |-> $stable(sda_oe_tgt))
        else $error("target moved data while clock high");
    a_start_then_low: assert property (start_ev |-> ##[1:1000] !scl)
        else $error("clock not pulled low after start");
    a_stop_bus_idle: assert property (stop_ev |=> (scl && sda) [*8])
        else $error("bus not idle after stop");
    a_tgt_drive_pulse: assert property (drive_wait_r < 11'h7D0)
        else $error("target pulled data without a following clock pulse");
    a_scl_high_hold: assert property ($rose(scl) |-> scl [*8])
        else $error("clock high phase too short");
    a_scl_low_hold: assert property ($fell(scl) |-> !scl [*8])
        else $error("clock low phase too short");
    a_scl_min_period: assert property ($rose(scl) |-> since_rise_r >= 8'h63)
        else $error("clock period below the fastest allowed");
endmodule // cmp_bus_monitor

//--- test/compass_i2c_slave_port_tb.sv
`timescale 1ns/1ps
module compass_i2c_slave_port_tb;
    import cmp_pkg::*;
    logic mclk;
    logic reset;
    logic address_select_pin;
    logic cmd_valid, cmd_start, cmd_stop, cmd_read, cmd_nack;
    logic [7:0] cmd_data;
    logic cmd_ready, rsp_valid, rsp_ack;
    logic [7:0] rsp_data;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic reg_wr, hs_mode, hs_seen;
    logic [7:0] ctl_mem [3];
    logic [15:0] wr_log [$];
    int n_mismatch = 0;
    int checks_done = 0;
    cmp_bus_if bus ();
    cmp_controller cmp_controller_inst (.mclk(mclk), .reset(reset), .bus(bus.controller),
        .cmd_valid(cmd_valid), .cmd_start(cmd_start), .cmd_stop(cmd_stop),
        .cmd_read(cmd_read), .cmd_nack(cmd_nack), .cmd_data(cmd_data),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ack(rsp_ack));
    cmp_target cmp_target_inst (.mclk(mclk), .reset(reset), .bus(bus.target),
        .address_select_pin(address_select_pin), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .hs_mode(hs_mode));
    cmp_bus_monitor cmp_bus_monitor_inst (.mclk(mclk), .reset(reset), .scl_oe(bus.scl_oe),
        .sda_oe_ctl(bus.sda_oe_ctl), .sda_oe_tgt(bus.sda_oe_tgt), .scl(bus.scl), .sda(bus.sda));
    // register file stand-in: control group writable, the rest a fixed pattern per address
    assign reg_rdata = (reg_addr >= 8'h30 && reg_addr <= 8'h32) ?
        ctl_mem[reg_addr[1:0]] : (reg_addr ^ 8'h5A);
    // log every write strobe; sticky flag because the mode level may drop before we look
    always @(posedge mclk) begin
        if (reset) begin
            ctl_mem[0] <= 8'hC0;
            ctl_mem[1] <= 8'hC1;
            ctl_mem[2] <= 8'hC2;
        end else if (reg_wr === 1'b1) begin
            wr_log.push_back({reg_addr, reg_wdata});
            if (reg_addr >= 8'h30 && reg_addr <= 8'h32) ctl_mem[reg_addr[1:0]] <= reg_wdata;
        end
        if (reset) begin
            hs_seen <= 1'b0;
        end else if (hs_mode === 1'b1) begin
            hs_seen <= 1'b1;
        end
    end
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one byte through the controller; returns once its answer has been seen
    task automatic xfer(input logic st, input logic sp, input logic rd, input logic nk,
        input logic [7:0] d);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 20000) begin
            @(negedge mclk);
            n++;
        end
        cmd_valid = 1'b1;
        cmd_start = st;
        cmd_stop = sp;
        cmd_read = rd;
        cmd_nack = nk;
        cmd_data = d;
        @(negedge mclk);
        cmd_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 20000) begin
            @(negedge mclk);
            n++;
        end
        check({15'h0000, rsp_valid}, 16'h0001);
    endtask
    // multi-byte write at the control group end: second data byte wraps to the group start
    task automatic sc_write_wrap();
        xfer(1'b1, 1'b0, 1'b0, 1'b0, {CMP_ADDR_LO, 1'b0});
        check({15'h0000, rsp_ack}, 16'h0001);
        xfer(1'b0, 1'b0, 1'b0, 1'b0, 8'h32);
        check({15'h0000, rsp_ack}, 16'h0001);
        xfer(1'b0, 1'b0, 1'b0, 1'b0, 8'h11);
        check({15'h0000, rsp_ack}, 16'h0001);
        xfer(1'b0, 1'b1, 1'b0, 1'b0, 8'h22);
        check({15'h0000, rsp_ack}, 16'h0001);
        check(16'(wr_log.size()), 16'h0002);
        check(wr_log[0], 16'h3211);
        check(wr_log[1], 16'h3022);
    endtask
    // current-address read continues after the last write, ack then nack
    task automatic sc_read_current();
        xfer(1'b1, 1'b0, 1'b0, 1'b0, {CMP_ADDR_LO, 1'b1});
        check({15'h0000, rsp_ack}, 16'h0001);
        xfer(1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
        check({8'h00, rsp_data}, 16'h00C1);
        xfer(1'b0, 1'b1, 1'b1, 1'b1, 8'h00);
        check({8'h00, rsp_data}, 16'h0011);
    endtask
    // strap high: pointer set by a write, restart, two reads across the low-group gap
    task automatic sc_random_read();
        address_select_pin = 1'b1;
        xfer(1'b1, 1'b0, 1'b0, 1'b0, {CMP_ADDR_HI, 1'b0});
        check({15'h0000, rsp_ack}, 16'h0001);
        xfer(1'b0, 1'b0, 1'b0, 1'b0, 8'h03);
        check({15'h0000, rsp_ack}, 16'h0001);
        xfer(1'b1, 1'b0, 1'b0, 1'b0, {CMP_ADDR_HI, 1'b1});
        check({15'h0000, rsp_ack}, 16'h0001);
        xfer(1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
        check({8'h00, rsp_data}, 16'h0059);
        xfer(1'b0, 1'b1, 1'b1, 1'b1, 8'h00);
        check({8'h00, rsp_data}, 16'h004A);
        address_select_pin = 1'b0;
    endtask
    // master code, then a foreign address at high speed, then back after the stop
    task automatic sc_high_speed();
        int n;
        xfer(1'b1, 1'b0, 1'b0, 1'b0, {CMP_HS_CODE, 3'h5});
        check({15'h0000, rsp_ack}, 16'h0000);
        check({15'h0000, hs_mode}, 16'h0000);
        xfer(1'b1, 1'b1, 1'b0, 1'b0, {CMP_ADDR_HI, 1'b0});
        check({15'h0000, rsp_ack}, 16'h0000);
        check({15'h0000, hs_seen}, 16'h0001);
        n = 0;
        while (cmd_ready !== 1'b1 && n < 20000) begin
            @(negedge mclk);
            n++;
        end
        repeat (20) @(negedge mclk);
        check({15'h0000, hs_mode}, 16'h0000);
        check(16'(wr_log.size()), 16'h0002);
    endtask
    task automatic give_verdict();
        $display("mismatches=%0d checks=%0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        reset = 1'b1;
        address_select_pin = 1'b0;
        cmd_valid = 1'b0;
        cmd_start = 1'b0;
        cmd_stop = 1'b0;
        cmd_read = 1'b0;
        cmd_nack = 1'b0;
        cmd_data = 8'h00;
        repeat (8) @(negedge mclk);
        reset = 1'b0;
        sc_write_wrap();
        sc_read_current();
        sc_random_read();
        sc_high_speed();
        give_verdict();
    end
    // fourteen bytes of about 6100 cycles each, about 85000; past that means a hang
    initial begin
        repeat (100000) @(posedge mclk);
        n_mismatch++;
        give_verdict();
    end
endmodule // compass_i2c_slave_port_tb
